//--- rtl/can_rx_fifo_id_filter.sv
// Notes on behaviour
// - first accepted frame: count 01, shown in mailbox
// - release bit drops count, shows next message
// - unreleased mailbox: count climbs to 10, 11
// - arrival at count 11 sets overrun flag
// - overrun, lock clear: newest entry overwritten
// - overrun, lock set: incoming frame discarded
// - count 00 to 01 raises pending interrupt
// - third stored message sets full flag, interrupt
// - overrun flag raises interrupt when enabled
// - six banks of eight configuration bytes
// - each bank chooses its own scale
// - wide scale compares std, ide, ext, rtr
// - half scale: two filters std, rtr, ide
// - byte scale: four filters on std[10:3]
// - mixed scale: one half plus two byte
// - mask mode compares only must-match bits
// - list mode: exact match to either identifier
// - frames no filter accepts are dropped
`timescale 1ns/1ps
`include "can_rx_defs.svh"
module can_rx_fifo_id_filter (
  // clock and reset
  input logic sys_clk_i,
  input logic rst_n_i,
  // axi4-lite write address
  input logic [7:0] s_axi_awaddr_i,
  input logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  // axi4-lite write data
  input logic [31:0] s_axi_wdata_i,
  input logic [3:0] s_axi_wstrb_i,
  input logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input logic s_axi_bready_i,
  // axi4-lite read address
  input logic [7:0] s_axi_araddr_i,
  input logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input logic s_axi_rready_i,
  // receive path
  input logic rx_valid_i,
  input logic [10:0] rx_std_id_i,
  input logic rx_ide_i,
  input logic rx_rtr_i,
  input logic [17:0] rx_ext_id_i,
  input logic [3:0] rx_dlc_i,
  input logic [63:0] rx_data_i,
  // interrupt
  output logic irq_o
);

  can_rx_pkg::top_state_t s_q;
  can_rx_pkg::top_state_t s_n;
  can_rx_pkg::rx_msg_t rx_msg;
  can_rx_pkg::rx_msg_t mbx;

  logic [5:0] hit;
  logic accept;
  logic do_wr;
  logic rel;
  logic ovr;
  logic we;
  logic [1:0] widx;
  logic [1:0] cnt_a;
  logic [1:0] rd_a;
  logic [1:0] cnt_n;
  logic [2:0] ists_set;
  logic [2:0] ists_clr;
  logic bank_wr;
  logic wr_hit;

  function automatic logic [1:0] add3(input logic [1:0] a, input logic [1:0] b);
    logic [2:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= 3'h3) begin
      s = s - 3'h3;
    end
    add3 = s[1:0];
  endfunction

  function automatic logic is_bank(input logic [7:0] a);
    is_bank = (a >= `OFS_BANK_BASE) && (a <= `OFS_BANK_LAST) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      `OFS_MASTER_CTRL, `OFS_IRQ_EN, `OFS_FIFO_STAT, `OFS_IRQ_STAT,
      `OFS_FLT_SCALE, `OFS_FLT_MODE, `OFS_FLT_ACT,
      `OFS_MBX_ID, `OFS_MBX_DLC, `OFS_MBX_DLO, `OFS_MBX_DHI: is_mapped = 1'b1;
      default: is_mapped = is_bank(a);
    endcase
  endfunction

  // ****************************************
  // filter banks
  // ****************************************
  assign rx_msg = {rx_std_id_i, rx_ide_i, rx_rtr_i, rx_ext_id_i, rx_dlc_i, rx_data_i};

  for (genvar b = 0; b < `NUM_BANKS; b++) begin : g_bank
    can_id_filter_bank u_bank (
      .cfg_i({s_q.fwords[2*b+1], s_q.fwords[2*b]}),
      .scale_i(can_rx_pkg::flt_scale_t'(s_q.scale[2*b+:2])),
      .list_i(s_q.mode[b]),
      .active_i(s_q.act[b]),
      .std_id_i(rx_std_id_i),
      .ide_i(rx_ide_i),
      .rtr_i(rx_rtr_i),
      .ext_id_i(rx_ext_id_i),
      .hit_o(hit[b])
    );
  end

  // ****************************************
  // receive fifo bookkeeping
  // ****************************************
  // a release and an arrival in one cycle are both honoured
  assign accept = rx_valid_i && (|hit);
  assign rel = do_wr && (s_q.awaddr == `OFS_FIFO_STAT) && s_q.wstrb[0] &&
               s_q.wdata[`BIT_RELEASE] && (s_q.cnt != 2'h0);
  assign cnt_a = s_q.cnt - {1'b0, rel};
  assign rd_a = rel ? add3(s_q.rd, 2'h1) : s_q.rd;
  assign ovr = accept && (cnt_a == 2'h3);
  assign we = accept && (!ovr || !s_q.lock);
  assign widx = ovr ? add3(rd_a, 2'h2) : add3(rd_a, cnt_a);
  assign cnt_n = (accept && !ovr) ? cnt_a + 2'h1 : cnt_a;
  assign ists_set[`BIT_IRQ_PEND] = accept && !ovr && (cnt_a == 2'h0);
  assign ists_set[`BIT_IRQ_FULL] = accept && !ovr && (cnt_a == 2'h2);
  assign ists_set[`BIT_IRQ_OVR] = ovr;
  assign ists_clr = (do_wr && (s_q.awaddr == `OFS_IRQ_STAT) && s_q.wstrb[0]) ?
                    s_q.wdata[2:0] : 3'h0;

  can_rx_store u_store (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .we_i(we),
    .widx_i(widx),
    .wmsg_i(rx_msg),
    .ridx_i(s_q.rd),
    .rmsg_o(mbx)
  );

  // ****************************************
  // register bus
  // ****************************************
  assign s_axi_awready_o = !s_q.aw_got && !s_q.bvalid;
  assign s_axi_wready_o = !s_q.w_got && !s_q.bvalid;
  assign s_axi_arready_o = !s_q.rvalid;
  assign s_axi_bvalid_o = s_q.bvalid;
  assign s_axi_bresp_o = s_q.bresp;
  assign s_axi_rvalid_o = s_q.rvalid;
  assign s_axi_rdata_o = s_q.rdata;
  assign s_axi_rresp_o = s_q.rresp;
  assign do_wr = s_q.aw_got && s_q.w_got && !s_q.bvalid;
  assign bank_wr = is_bank(s_q.awaddr);
  assign wr_hit = is_mapped(s_q.awaddr);

  function automatic logic [31:0] rd_reg(input can_rx_pkg::top_state_t s,
                                         input can_rx_pkg::rx_msg_t m,
                                         input logic [7:0] a);
    logic [3:0] wi;
    wi = a[5:2];
    case (a)
      `OFS_MASTER_CTRL: rd_reg = {31'h0, s.lock};
      `OFS_IRQ_EN: rd_reg = {29'h0, s.ien};
      `OFS_FIFO_STAT: rd_reg = {27'h0, s.ists[`BIT_IRQ_OVR], s.ists[`BIT_IRQ_FULL],
                                1'b0, s.cnt};
      `OFS_IRQ_STAT: rd_reg = {29'h0, s.ists};
      `OFS_FLT_SCALE: rd_reg = {20'h0, s.scale};
      `OFS_FLT_MODE: rd_reg = {26'h0, s.mode};
      `OFS_FLT_ACT: rd_reg = {26'h0, s.act};
      `OFS_MBX_ID: rd_reg = {1'b0, m.std_id, m.ide, m.rtr, m.ext_id};
      `OFS_MBX_DLC: rd_reg = {28'h0, m.dlc};
      `OFS_MBX_DLO: rd_reg = m.data[31:0];
      `OFS_MBX_DHI: rd_reg = m.data[63:32];
      default: rd_reg = is_bank(a) ? s.fwords[wi] : 32'h0;
    endcase
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_n = s_q;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      s_n.aw_got = 1'b1;
      s_n.awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      s_n.w_got = 1'b1;
      s_n.wdata = s_axi_wdata_i;
      s_n.wstrb = s_axi_wstrb_i;
    end
    if (s_q.bvalid && s_axi_bready_i) begin
      s_n.bvalid = 1'b0;
    end
    if (do_wr) begin
      s_n.aw_got = 1'b0;
      s_n.w_got = 1'b0;
      s_n.bvalid = 1'b1;
      s_n.bresp = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      if (s_q.wstrb[0]) begin
        case (s_q.awaddr)
          `OFS_MASTER_CTRL: s_n.lock = s_q.wdata[`BIT_LOCK];
          `OFS_IRQ_EN: s_n.ien = s_q.wdata[2:0];
          `OFS_FLT_SCALE: s_n.scale[7:0] = s_q.wdata[7:0];
          `OFS_FLT_MODE: s_n.mode = s_q.wdata[5:0];
          `OFS_FLT_ACT: s_n.act = s_q.wdata[5:0];
          default: ;
        endcase
      end
      if (s_q.wstrb[1] && (s_q.awaddr == `OFS_FLT_SCALE)) begin
        s_n.scale[11:8] = s_q.wdata[11:8];
      end
      // byte lanes let software patch one filter byte alone
      for (int k = 0; k < 4; k++) begin
        if (bank_wr && s_q.wstrb[k]) begin
          s_n.fwords[s_q.awaddr[5:2]][8*k+:8] = s_q.wdata[8*k+:8];
        end
      end
    end
    s_n.cnt = cnt_n;
    s_n.rd = rd_a;
    // a new event wins over a clear in the same cycle
    s_n.ists = (s_q.ists & ~ists_clr) | ists_set;
    if (s_q.rvalid && s_axi_rready_i) begin
      s_n.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_n.rvalid = 1'b1;
      s_n.rdata = rd_reg(s_q, mbx, s_axi_araddr_i);
      s_n.rresp = is_mapped(s_axi_araddr_i) ? `RESP_OKAY : `RESP_SLVERR;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= `RST_STATE;
    end else begin
      s_q <= s_n;
    end
  end

  assign irq_o = |(s_q.ists & s_q.ien);

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_first_store;
    (s_q.cnt == 2'h0 && accept) |=>
      (s_q.cnt == 2'h1 && mbx.std_id == $past(rx_std_id_i));
  endproperty
  a_first_store: assert property (p_first_store)
    else $error("first frame not presented");

  property p_release;
    (rel && !accept) |=> (s_q.cnt == $past(s_q.cnt) - 2'h1);
  endproperty
  a_release: assert property (p_release)
    else $error("release did not drop count");

  property p_climb;
    (s_q.cnt == 2'h1 && accept && !rel) ##1 (accept && !rel) |=> s_q.cnt == 2'h3;
  endproperty
  a_climb: assert property (p_climb)
    else $error("count did not climb to three");

  property p_overrun;
    (s_q.cnt == 2'h3 && accept && !rel) |=> (s_q.ists[2] && s_q.cnt == 2'h3);
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not flagged");

  property p_overwrite;
    (ovr && !s_q.lock) |-> (we && widx == add3(s_q.rd, 2'h2));
  endproperty
  a_overwrite: assert property (p_overwrite)
    else $error("newest entry not overwritten");

  property p_lock;
    (ovr && s_q.lock) |-> !we ##1 $stable(mbx);
  endproperty
  a_lock: assert property (p_lock)
    else $error("locked fifo was written");

  property p_pend_irq;
    (s_q.cnt == 2'h0 && accept && s_q.ien[0]) |=> irq_o;
  endproperty
  a_pend_irq: assert property (p_pend_irq)
    else $error("pending interrupt missing");

  property p_full;
    (s_q.cnt == 2'h2 && accept && !rel) |=> (s_q.ists[1] && s_q.cnt == 2'h3);
  endproperty
  a_full: assert property (p_full)
    else $error("full flag missing");

  property p_ovr_irq;
    (ovr && s_q.ien[2]) |=> irq_o;
  endproperty
  a_ovr_irq: assert property (p_ovr_irq)
    else $error("overrun interrupt missing");

  property p_drop;
    (rx_valid_i && hit == 6'h0) |-> !we ##1 (s_q.cnt == $past(cnt_a));
  endproperty
  a_drop: assert property (p_drop)
    else $error("unfiltered frame stored");

  property p_accept;
    (rx_valid_i && (|hit) && cnt_a != 2'h3) |=> (s_q.cnt == $past(cnt_a) + 2'h1);
  endproperty
  a_accept: assert property (p_accept)
    else $error("accepted frame not stored");

  // the oldest entry must survive an unlocked overrun
  property p_ovr_keep;
    (ovr && !s_q.lock) |=> ($stable(mbx) && s_q.cnt == 2'h3);
  endproperty
  a_ovr_keep: assert property (p_ovr_keep)
    else $error("overrun disturbed the mailbox");

  property p_ovr_sticky;
    (s_q.ists[`BIT_IRQ_OVR] && !(do_wr && s_q.awaddr == `OFS_IRQ_STAT &&
      s_q.wdata[`BIT_IRQ_OVR])) |=> s_q.ists[`BIT_IRQ_OVR];
  endproperty
  a_ovr_sticky: assert property (p_ovr_sticky)
    else $error("overrun flag lost without a clear");

  property p_drop_mbx;
    (rx_valid_i && hit == 6'h0 && !rel) |=> $stable(mbx);
  endproperty
  a_drop_mbx: assert property (p_drop_mbx)
    else $error("rejected frame reached the mailbox");

endmodule

//--- rtl/can_rx_defs.svh
`ifndef CAN_RX_DEFS_SVH
`define CAN_RX_DEFS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define OFS_MASTER_CTRL 8'h00
`define OFS_IRQ_EN 8'h04
`define OFS_FIFO_STAT 8'h08
`define OFS_IRQ_STAT 8'h0c
`define OFS_FLT_SCALE 8'h10
`define OFS_FLT_MODE 8'h14
`define OFS_FLT_ACT 8'h18
`define OFS_MBX_ID 8'h20
`define OFS_MBX_DLC 8'h24
`define OFS_MBX_DLO 8'h28
`define OFS_MBX_DHI 8'h2c
`define OFS_BANK_BASE 8'h40
`define OFS_BANK_LAST 8'h6c

// ****************************************
// field positions
// ****************************************
`define BIT_LOCK 0
`define BIT_IRQ_PEND 0
`define BIT_IRQ_FULL 1
`define BIT_IRQ_OVR 2
`define BIT_STAT_FULL 3
`define BIT_STAT_OVR 4
`define BIT_RELEASE 5

// ****************************************
// sizes, reset values, answers
// ****************************************
`define NUM_BANKS 6
`define FIFO_DEPTH 3
`define RST_STATE '0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- rtl/can_rx_pkg.sv
package can_rx_pkg;

  typedef struct packed {
    logic [10:0] std_id;
    logic ide;
    logic rtr;
    logic [17:0] ext_id;
    logic [3:0] dlc;
    logic [63:0] data;
  } rx_msg_t;

  typedef enum logic [1:0] {
    SCALE_8 = 2'h0,
    SCALE_16 = 2'h1,
    SCALE_32 = 2'h2,
    SCALE_MIX = 2'h3
  } flt_scale_t;

  typedef struct packed {
    rx_msg_t [2:0] ent;
  } store_state_t;

  typedef struct packed {
    logic lock;
    logic [2:0] ien;
    logic [2:0] ists;
    logic [1:0] cnt;
    logic [1:0] rd;
    logic [11:0] scale;
    logic [5:0] mode;
    logic [5:0] act;
    logic [11:0][31:0] fwords;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } top_state_t;

endpackage

//--- rtl/can_rx_store.sv
`timescale 1ns/1ps
`include "can_rx_defs.svh"
module can_rx_store (
  // clock and reset
  input logic sys_clk_i,
  input logic rst_n_i,
  // write side
  input logic we_i,
  input logic [1:0] widx_i,
  input can_rx_pkg::rx_msg_t wmsg_i,
  // read side
  input logic [1:0] ridx_i,
  output can_rx_pkg::rx_msg_t rmsg_o
);

  can_rx_pkg::store_state_t s_q;
  can_rx_pkg::store_state_t s_n;

  always_comb begin
    s_n = s_q;
    if (we_i) begin
      s_n.ent[widx_i] = wmsg_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= `RST_STATE;
    end else begin
      s_q <= s_n;
    end
  end

  // index 3 never occurs, the fifo logic wraps at three
  assign rmsg_o = s_q.ent[ridx_i];

endmodule

//--- rtl/can_id_filter_bank.sv
`timescale 1ns/1ps
module can_id_filter_bank (
  // bank configuration
  input logic [63:0] cfg_i,
  input can_rx_pkg::flt_scale_t scale_i,
  input logic list_i,
  input logic active_i,
  // received identifier
  input logic [10:0] std_id_i,
  input logic ide_i,
  input logic rtr_i,
  input logic [17:0] ext_id_i,
  // result
  output logic hit_o
);

  logic [7:0] b [8];
  logic [31:0] v32;
  logic [31:0] v16;
  logic [31:0] v8;
  logic f32;
  logic f16a;
  logic f16b;
  logic [3:0] f8;

  function automatic logic cmp(input logic [31:0] v, input logic [31:0] a,
                               input logic [31:0] m, input logic [31:0] wm,
                               input logic lst);
    logic [31:0] d0;
    logic [31:0] d1;
    d0 = (v ^ a) & wm;
    d1 = (v ^ m) & wm;
    if (lst) begin
      cmp = (d0 == 32'h0) || (d1 == 32'h0);
    end else begin
      cmp = (d0 & m) == 32'h0;
    end
  endfunction

  for (genvar k = 0; k < 8; k++) begin : g_byte
    assign b[k] = cfg_i[8*k+:8];
  end

  assign v32 = {std_id_i, rtr_i, ide_i, ext_id_i, 1'b0};
  assign v16 = {16'h0, std_id_i, rtr_i, ide_i, 3'h0};
  assign v8 = {24'h0, std_id_i[10:3]};

  // lowest bit of the wide word is unused
  assign f32 = cmp(v32, {b[0], b[1], b[2], b[3]}, {b[4], b[5], b[6], b[7]},
                   32'hffff_fffe, list_i);
  assign f16a = cmp(v16, {16'h0, b[0], b[1]}, {16'h0, b[2], b[3]},
                    32'h0000_fff8, list_i);
  assign f16b = cmp(v16, {16'h0, b[4], b[5]}, {16'h0, b[6], b[7]},
                    32'h0000_fff8, list_i);

  for (genvar k = 0; k < 4; k++) begin : g_f8
    assign f8[k] = cmp(v8, {24'h0, b[2*k]}, {24'h0, b[2*k+1]},
                       32'h0000_00ff, list_i);
  end

  always_comb begin
    case (scale_i)
      can_rx_pkg::SCALE_32: hit_o = active_i && f32;
      can_rx_pkg::SCALE_16: hit_o = active_i && (f16a || f16b);
      can_rx_pkg::SCALE_8: hit_o = active_i && (|f8);
      can_rx_pkg::SCALE_MIX: hit_o = active_i && (f16a || f8[2] || f8[3]);
      default: hit_o = 1'b0;
    endcase
  end

endmodule

//--- test/can_rx_frame_src.sv
`timescale 1ns/1ps
module can_rx_frame_src (
  // clock
  input wire logic clk_i,
  // received frame
  output logic valid_o,
  output logic [10:0] std_id_o,
  output logic ide_o,
  output logic rtr_o,
  output logic [17:0] ext_id_o,
  output logic [3:0] dlc_o,
  output logic [63:0] data_o
);
  can_rx_pkg::rx_msg_t fr [4];

  initial begin
    valid_o = 1'b0;
    {std_id_o, ide_o, rtr_o, ext_id_o, dlc_o, data_o} = '0;
  end

  // ****************************************
  // frame delivery
  // ****************************************
  // frames leave back to back, one a cycle; fields are scrambled
  // afterwards so a stale frame can never pass for a fresh one
  task automatic burst(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      valid_o <= 1'b1;
      {std_id_o, ide_o, rtr_o, ext_id_o, dlc_o, data_o} <= fr[i];
    end
    @(posedge clk_i);
    valid_o <= 1'b0;
    {std_id_o, ide_o, rtr_o, ext_id_o, dlc_o, data_o} <= ~fr[n-1];
  endtask
endmodule

//--- test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid, irq, rx_valid, rx_ide, rx_rtr;
  logic [1:0] bresp, rresp;
  logic [10:0] rx_std;
  logic [17:0] rx_ext;
  logic [3:0] rx_dlc;
  logic [63:0] rx_data;
  can_rx_pkg::rx_msg_t fa, fb, fc, fd, fe, rj;
  int error_cnt = 0, n_compared = 0, cyc = 0;
  logic [31:0] v;
  logic [1:0] r;

  always #5 sys_clk_i = ~sys_clk_i;

  can_rx_fifo_id_filter can_rx_fifo_id_filter_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .rx_valid_i(rx_valid),
    .rx_std_id_i(rx_std), .rx_ide_i(rx_ide), .rx_rtr_i(rx_rtr), .rx_ext_id_i(rx_ext),
    .rx_dlc_i(rx_dlc), .rx_data_i(rx_data), .irq_o(irq));

  can_rx_frame_src can_rx_frame_src_inst (.clk_i(sys_clk_i), .valid_o(rx_valid),
    .std_id_o(rx_std), .ide_o(rx_ide), .rtr_o(rx_rtr), .ext_id_o(rx_ext),
    .dlc_o(rx_dlc), .data_o(rx_data));

  // ****************************************
  // bus tasks and checks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    forever begin
      @(posedge sys_clk_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk_i);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    forever begin
      @(posedge sys_clk_i);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
    rd(a);
    chk(nm, v & m, e);
  endtask

  task automatic irqchk(input logic e);
    #1;
    chk("irq_o", {31'h0, irq}, {31'h0, e});
  endtask

  // pops the mailbox after checking its payload
  task automatic pop(input can_rx_pkg::rx_msg_t f);
    rdchk("mailbox data", 8'h28, 32'hffffffff, f.data[31:0]);
    wr(8'h08, 32'h20);
  endtask

  function automatic logic [31:0] idw(input can_rx_pkg::rx_msg_t f);
    return {f.ext_id[6:0], 1'b0, f.ext_id[14:7], f.std_id[2:0], f.rtr, f.ide,
            f.ext_id[17:15], f.std_id[10:3]};
  endfunction

  task automatic send(input can_rx_pkg::rx_msg_t a, b, c, d, input int n);
    can_rx_frame_src_inst.fr[0] = a;
    can_rx_frame_src_inst.fr[1] = b;
    can_rx_frame_src_inst.fr[2] = c;
    can_rx_frame_src_inst.fr[3] = d;
    can_rx_frame_src_inst.burst(n);
  endtask

  task automatic give_verdict();
    if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    fa = '{11'h121, 1'b0, 1'b0, 18'h0, 4'h8, 64'h0a};
    fb = '{11'h555, 1'b1, 1'b0, 18'h2aaaa, 4'h8, 64'h0b};
    fc = '{11'h127, 1'b1, 1'b1, 18'h1, 4'h1, 64'h0c};
    fd = '{11'h124, 1'b0, 1'b0, 18'h0, 4'h2, 64'h0d};
    fe = '{11'h300, 1'b0, 1'b0, 18'h0, 4'h0, 64'h0};
    rj = fb;
    rj.rtr = 1'b1;
    repeat (8) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rdchk("fifo status", 8'h08, 32'hffffffff, 32'h0);
    rdchk("irq status", 8'h0c, 32'hffffffff, 32'h0);
    rdchk("unmapped read", 8'h30, 32'hffffffff, 32'h0);
    chk("unmapped rresp", {30'h0, r}, 32'h2);
    wr(8'h34, 32'h1);
    chk("unmapped bresp", {30'h0, r}, 32'h2);
    // bank0 byte scale mask, bank1 wide scale list
    wr(8'h40, 32'hff24ff24);
    wr(8'h44, 32'hff24ff24);
    wr(8'h48, idw(fb));
    wr(8'h4c, idw(fb));
    wr(8'h10, 32'h8);
    wr(8'h14, 32'h2);
    wr(8'h18, 32'h3);
    wr(8'h04, 32'h7);
    send(rj, fe, fa, fa, 2);
    rdchk("count after rejects", 8'h08, 32'h3, 32'h0);
    rdchk("irq after rejects", 8'h0c, 32'h7, 32'h0);
    send(fa, fa, fa, fa, 1);
    rdchk("count one", 8'h08, 32'h3, 32'h1);
    rdchk("mailbox id", 8'h20, 32'hffffffff, {1'b0, fa.std_id, fa.ide, fa.rtr, fa.ext_id});
    rdchk("pending event", 8'h0c, 32'h7, 32'h1);
    irqchk(1'b1);
    wr(8'h0c, 32'h7);
    irqchk(1'b0);
    send(fb, fc, fa, fa, 2);
    rdchk("count three", 8'h08, 32'h3, 32'h3);
    rdchk("full flag", 8'h08, 32'h18, 32'h8);
    rdchk("full event", 8'h0c, 32'h7, 32'h2);
    send(fd, fa, fa, fa, 1);
    rdchk("overrun flag", 8'h08, 32'h13, 32'h13);
    rdchk("overrun event", 8'h0c, 32'h7, 32'h6);
    irqchk(1'b1);
    pop(fa);
    rdchk("count two", 8'h08, 32'h3, 32'h2);
    pop(fb);
    pop(fd);
    rdchk("count zero", 8'h08, 32'h3, 32'h0);
    wr(8'h0c, 32'h7);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h1);
    send(fa, fb, fc, fd, 4);
    rdchk("masked events", 8'h0c, 32'h7, 32'h7);
    irqchk(1'b0);
    pop(fa);
    pop(fb);
    pop(fc);
    rdchk("count drained", 8'h08, 32'h3, 32'h0);
    wr(8'h04, 32'h4);
    irqchk(1'b1);
    // bank0 alone: half scale, then mixed; the 0x300 frame tells them apart
    wr(8'h40, 32'hf8ffa8aa);
    wr(8'h44, 32'hff60ff60);
    wr(8'h18, 32'h1);
    wr(8'h10, 32'h1);
    send(rj, fb, fe, fa, 3);
    rdchk("half scale count", 8'h08, 32'h3, 32'h1);
    pop(fb);
    wr(8'h10, 32'h3);
    send(fe, rj, fb, fa, 3);
    rdchk("mixed scale count", 8'h08, 32'h3, 32'h2);
    rdchk("mixed id", 8'h20, 32'hffffffff, {1'b0, fe.std_id, fe.ide, fe.rtr, fe.ext_id});
    pop(fe);
    pop(fb);
    give_verdict();
  end
endmodule
